// [include/lvdsm_pkg.sv]
// package: register map, field layout, reset values and timing for level detect and stream mapping
package lvdsm_pkg;
  // register offsets
  localparam logic [11:0] APP_MODE_OFF = 12'h200;
  localparam logic [11:0] DEC_RATIO_OFF = 12'h201;
  localparam logic [11:0] UPPER_LO_OFF = 12'h247;
  localparam logic [11:0] UPPER_HI_OFF = 12'h248;
  localparam logic [11:0] LOWER_LO_OFF = 12'h249;
  localparam logic [11:0] LOWER_HI_OFF = 12'h24A;
  localparam logic [11:0] DWELL_LO_OFF = 12'h24B;
  localparam logic [11:0] DWELL_HI_OFF = 12'h24C;
  localparam logic [11:0] OVR_CLEAR_OFF = 12'h562;
  localparam logic [11:0] OVR_STATUS_OFF = 12'h563;
  localparam logic [11:0] STBY_PAYLOAD_OFF = 12'h571;
  // field positions
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int REAL_SEL_BIT = 5;
  localparam int DEC_W = 4;
  localparam int STBY_K_BIT = 7;
  localparam int THR_W = 13;
  localparam int DWELL_W = 16;
  // reset values
  localparam logic [7:0] APP_MODE_RST = 8'h00;
  localparam logic [7:0] DEC_RATIO_RST = 8'h01;
  localparam logic [THR_W-1:0] UPPER_RST = 13'h1FFF;
  localparam logic [THR_W-1:0] LOWER_RST = 13'h0000;
  localparam logic [DWELL_W-1:0] DWELL_RST = 16'h0001;
  localparam logic [7:0] STBY_PAYLOAD_RST = 8'h00;
  // operating modes
  localparam logic [3:0] MODE_FULL_BW = 4'h0;
  localparam logic [3:0] MODE_ONE_DDC = 4'h1;
  localparam logic [3:0] MODE_TWO_DDC = 4'h2;
  localparam logic [3:0] MODE_FOUR_DDC = 4'h3;
  // timing: the detect pipe is a fixed 3 cycles, well under the 28-cycle bound
  localparam int FD_MAX_LATENCY = 28;
  localparam int FD_PIPE = 3;
  localparam int NUM_VC = 8;
  localparam logic [7:0] K_CHAR = 8'hBC;

  typedef enum logic [1:0] {
    LVDSM_LINK_RUN,
    LVDSM_LINK_STANDBY,
    LVDSM_LINK_HALT
  } lvdsm_link_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lvdsm_reg_req_s;

  typedef struct packed {
    logic [15:0] data;
    logic ovr;
    logic ctrl_k;
  } lvdsm_vc_s;
endpackage

// [rtl/lvdsm_top.sv]
// module: fast threshold detect, overrange status and virtual converter mapping
`timescale 1ns/100ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module lvdsm_top #(
  parameter int SAMPLE_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire lvdsm_pkg::lvdsm_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [SAMPLE_W-1:0] adc_a,
  input wire logic [SAMPLE_W-1:0] adc_b,
  input wire logic adc_a_ovr,
  input wire logic adc_b_ovr,
  input wire logic [SAMPLE_W-1:0] ddc_i [4],
  input wire logic [SAMPLE_W-1:0] ddc_q [4],
  input wire logic [1:0] control_bits_per_sample,
  input wire logic powerdown_standby_pin,
  input wire logic powerdown_reg,
  input wire logic pin_is_standby,
  output logic threshold_flag_out_a,
  output logic threshold_flag_out_b,
  output lvdsm_pkg::lvdsm_vc_s vc_out [8],
  output logic vc_sample_en,
  output logic [3:0] vc_count,
  output logic link_enable
);
  import lvdsm_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] app_mode_q;
  logic [7:0] dec_ratio_q;
  logic [THR_W-1:0] upper_q;
  logic [THR_W-1:0] lower_q;
  logic [DWELL_W-1:0] dwell_q;
  logic [7:0] ovr_clear_q;
  logic [7:0] ovr_status_q;
  logic [7:0] stby_payload_q;

  // application mode and decimation ratio
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      app_mode_q <= APP_MODE_RST;
      dec_ratio_q <= DEC_RATIO_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == APP_MODE_OFF) begin
        app_mode_q <= reg_req.wdata;
      end else if (reg_req.addr == DEC_RATIO_OFF) begin
        dec_ratio_q <= reg_req.wdata;
      end
    end
  end

  // thresholds; a half-written pair is live at once, so program the high byte last
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upper_q <= UPPER_RST;
      lower_q <= LOWER_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == UPPER_LO_OFF) begin
        upper_q[7:0] <= reg_req.wdata;
      end else if (reg_req.addr == UPPER_HI_OFF) begin
        upper_q[THR_W-1:8] <= reg_req.wdata[THR_W-9:0];
      end else if (reg_req.addr == LOWER_LO_OFF) begin
        lower_q[7:0] <= reg_req.wdata;
      end else if (reg_req.addr == LOWER_HI_OFF) begin
        lower_q[THR_W-1:8] <= reg_req.wdata[THR_W-9:0];
      end
    end
  end

  // dwell count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dwell_q <= DWELL_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == DWELL_LO_OFF) begin
        dwell_q[7:0] <= reg_req.wdata;
      end else if (reg_req.addr == DWELL_HI_OFF) begin
        dwell_q[15:8] <= reg_req.wdata;
      end
    end
  end

  // overrange clear control and standby payload
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovr_clear_q <= 8'h00;
      stby_payload_q <= STBY_PAYLOAD_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OVR_CLEAR_OFF) begin
        ovr_clear_q <= reg_req.wdata;
      end else if (reg_req.addr == STBY_PAYLOAD_OFF) begin
        stby_payload_q <= reg_req.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  // read mux, unmapped offsets read zero
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_req.addr == APP_MODE_OFF) begin
      reg_rdata = app_mode_q;
    end else if (reg_req.addr == DEC_RATIO_OFF) begin
      reg_rdata = dec_ratio_q;
    end else if (reg_req.addr == UPPER_LO_OFF) begin
      reg_rdata = upper_q[7:0];
    end else if (reg_req.addr == UPPER_HI_OFF) begin
      reg_rdata = {3'h0, upper_q[THR_W-1:8]};
    end else if (reg_req.addr == LOWER_LO_OFF) begin
      reg_rdata = lower_q[7:0];
    end else if (reg_req.addr == LOWER_HI_OFF) begin
      reg_rdata = {3'h0, lower_q[THR_W-1:8]};
    end else if (reg_req.addr == DWELL_LO_OFF) begin
      reg_rdata = dwell_q[7:0];
    end else if (reg_req.addr == DWELL_HI_OFF) begin
      reg_rdata = dwell_q[15:8];
    end else if (reg_req.addr == OVR_CLEAR_OFF) begin
      reg_rdata = ovr_clear_q;
    end else if (reg_req.addr == OVR_STATUS_OFF) begin
      reg_rdata = ovr_status_q;
    end else if (reg_req.addr == STBY_PAYLOAD_OFF) begin
      reg_rdata = stby_payload_q;
    end
  end

  // ------------------------------------------------------------
  // fast threshold detectors, one per channel
  // ------------------------------------------------------------
  logic [SAMPLE_W-1:0] chan_sample [2];
  logic [1:0] flag;
  assign chan_sample[0] = adc_a;
  assign chan_sample[1] = adc_b;

  for (genvar c = 0; c < 2; c++) begin : g_fd
    logic [THR_W-1:0] mag_q;
    logic above_q;
    logic below_q;
    logic [DWELL_W:0] run_q;
    logic flag_q;
    logic [SAMPLE_W-1:0] s;
    logic [SAMPLE_W-1:0] a;
    assign s = chan_sample[c];
    // magnitude of the adc output scaled to 13 bits, full scale is 2^13 - 1
    assign a = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        mag_q <= '0;
        above_q <= 1'b0;
        below_q <= 1'b0;
      end else begin
        mag_q <= a[SAMPLE_W-1] ? {THR_W{1'b1}} : a[SAMPLE_W-2 -: THR_W];
        above_q <= mag_q > upper_q;
        below_q <= mag_q < lower_q;
      end
    end
    // run counter saturates one past the top dwell value
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        run_q <= '0;
      end else if (!below_q) begin
        run_q <= '0;
      end else if (!run_q[DWELL_W]) begin
        run_q <= run_q + 1'b1;
      end
    end
    // set wins over clear; sample to flag takes FD_PIPE clocks
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        flag_q <= 1'b0;
      end else if (above_q) begin
        flag_q <= 1'b1;
      end else if (below_q && run_q >= {1'b0, dwell_q}) begin
        flag_q <= 1'b0;
      end
    end
    assign flag[c] = flag_q;
  end

  assign threshold_flag_out_a = flag[0];
  assign threshold_flag_out_b = flag[1];

  // ------------------------------------------------------------
  // decimation enable
  // ------------------------------------------------------------
  logic [DEC_W-1:0] dec_cnt_q;
  logic [DEC_W-1:0] dec_ratio;
  assign dec_ratio = (dec_ratio_q[DEC_W-1:0] == '0) ? DEC_W'(1) : dec_ratio_q[DEC_W-1:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dec_cnt_q <= '0;
      vc_sample_en <= 1'b0;
    end else begin
      vc_sample_en <= (dec_cnt_q == '0);
      if (dec_cnt_q >= dec_ratio - 1'b1) begin
        dec_cnt_q <= '0;
      end else begin
        dec_cnt_q <= dec_cnt_q + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // link state
  // ------------------------------------------------------------
  lvdsm_link_e link_state;
  always_comb begin
    link_state = LVDSM_LINK_RUN;
    if (powerdown_reg || (powerdown_standby_pin && !pin_is_standby)) begin
      link_state = LVDSM_LINK_HALT;
    end else if (powerdown_standby_pin && pin_is_standby) begin
      link_state = LVDSM_LINK_STANDBY;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_enable <= 1'b0;
    end else begin
      link_enable <= (link_state != LVDSM_LINK_HALT);
    end
  end

  // ------------------------------------------------------------
  // virtual converter mapping
  // ------------------------------------------------------------
  logic [3:0] mode;
  logic real_sel;
  logic [SAMPLE_W-1:0] map_data [8];
  logic [7:0] map_ovr;
  logic [3:0] map_count;
  assign mode = app_mode_q[MODE_LSB +: MODE_W];
  assign real_sel = app_mode_q[REAL_SEL_BIT];

  // ddc outputs share the overrange of the adc feeding them; ddc 0,2 from a, 1,3 from b
  always_comb begin
    for (int v = 0; v < NUM_VC; v++) begin
      map_data[v] = '0;
    end
    map_ovr = 8'h00;
    map_count = 4'h0;
    case (mode)
      MODE_FULL_BW: begin
        map_data[0] = adc_a;
        map_data[1] = adc_b;
        map_ovr[1:0] = {adc_b_ovr, adc_a_ovr};
        map_count = 4'h2;
      end
      MODE_ONE_DDC, MODE_TWO_DDC, MODE_FOUR_DDC: begin
        map_count = (mode == MODE_FOUR_DDC) ? 4'h4 : mode;
        for (int d = 0; d < 4; d++) begin
          if (d < int'(map_count)) begin
            if (real_sel) begin
              map_data[d] = ddc_i[d];
              map_ovr[d] = d[0] ? adc_b_ovr : adc_a_ovr;
            end else begin
              map_data[2*d] = ddc_i[d];
              map_data[2*d+1] = ddc_q[d];
              map_ovr[2*d] = d[0] ? adc_b_ovr : adc_a_ovr;
              map_ovr[2*d+1] = d[0] ? adc_b_ovr : adc_a_ovr;
            end
          end
        end
        if (!real_sel) begin
          map_count = 4'(map_count << 1);
        end
      end
      default: begin
        map_count = 4'h0;
      end
    endcase
  end

  // output stage; overrange uses the same single register stage as the data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int v = 0; v < NUM_VC; v++) begin
        vc_out[v] <= '0;
      end
      vc_count <= 4'h0;
    end else begin
      vc_count <= map_count;
      for (int v = 0; v < NUM_VC; v++) begin
        if (link_state == LVDSM_LINK_STANDBY) begin
          vc_out[v].data <= stby_payload_q[STBY_K_BIT] ? {K_CHAR, K_CHAR} : '0;
          vc_out[v].ctrl_k <= stby_payload_q[STBY_K_BIT];
          vc_out[v].ovr <= 1'b0;
        end else begin
          vc_out[v].data <= 16'(map_data[v]);
          vc_out[v].ctrl_k <= 1'b0;
          vc_out[v].ovr <= (control_bits_per_sample != 2'h0) && map_ovr[v];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // sticky overrange status
  // ------------------------------------------------------------
  logic [7:0] clear_fall;
  logic clr_wr;
  assign clr_wr = reg_req.wr && (reg_req.addr == OVR_CLEAR_OFF);
  // clear fires on the write that returns a bit from set to reset
  assign clear_fall = clr_wr ? (ovr_clear_q & ~reg_req.wdata) : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovr_status_q <= 8'h00;
    end else begin
      // a new overrange in the clearing cycle is kept
      ovr_status_q <= (ovr_status_q & ~clear_fall) | map_ovr;
    end
  end
endmodule

// [verif/lvdsm_assertions.sv]
// checker: fast detect, mapping, sticky overrange and link state
`timescale 1ns/100ps
module lvdsm_assertions #(
  parameter int SAMPLE_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire lvdsm_pkg::lvdsm_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [SAMPLE_W-1:0] adc_a,
  input wire logic [SAMPLE_W-1:0] adc_b,
  input wire logic adc_a_ovr,
  input wire logic [SAMPLE_W-1:0] ddc_i [4],
  input wire logic [SAMPLE_W-1:0] ddc_q [4],
  input wire logic [1:0] control_bits_per_sample,
  input wire logic powerdown_standby_pin,
  input wire logic powerdown_reg,
  input wire logic pin_is_standby,
  input wire logic threshold_flag_out_a,
  input wire logic threshold_flag_out_b,
  input wire lvdsm_pkg::lvdsm_vc_s vc_out [8],
  input wire logic [3:0] vc_count,
  input wire logic link_enable
);
  import lvdsm_pkg::*;
  logic [12:0] up_q, lo_q;
  logic [7:0] mode_q;
  logic quiet;
  assign quiet = !powerdown_standby_pin && !powerdown_reg;
  // shadow of the registers the rules depend on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      up_q <= UPPER_RST;
      lo_q <= LOWER_RST;
      mode_q <= APP_MODE_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        UPPER_LO_OFF: up_q[7:0] <= reg_req.wdata;
        UPPER_HI_OFF: up_q[12:8] <= reg_req.wdata[4:0];
        LOWER_LO_OFF: lo_q[7:0] <= reg_req.wdata;
        LOWER_HI_OFF: lo_q[12:8] <= reg_req.wdata[4:0];
        APP_MODE_OFF: mode_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end
  // most negative code has no positive twin, so it saturates
  function automatic logic [12:0] mag(input logic [SAMPLE_W-1:0] s);
    logic [15:0] m;
    m = s[15] ? 16'h0000 - s : s;
    return m[15] ? 13'h1FFF : m[14:2];
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_FD_A_SET: assert property (mag(adc_a) > up_q |-> ##[1:28] threshold_flag_out_a)
    else $error("flag a not raised in time");
  AST_FD_B_SET: assert property (mag(adc_b) > up_q |-> ##[1:28] threshold_flag_out_b)
    else $error("flag b not raised in time");
  AST_FD_A_KEEP: assert property ((mag(adc_a) >= lo_q) [*6] |=> !$fell(threshold_flag_out_a))
    else $error("flag a dropped without a low run");
  AST_LINK_HALT: assert property (powerdown_reg || (powerdown_standby_pin && !pin_is_standby) |=> !link_enable)
    else $error("link runs in power-down");
  AST_STBY: assert property (powerdown_standby_pin && pin_is_standby && !powerdown_reg |=> link_enable &&
    (vc_out[0].ctrl_k ? vc_out[0].data == {2{K_CHAR}} : vc_out[0].data == 16'h0000))
    else $error("standby payload wrong");
  AST_VC_PAIR: assert property ($past(!rst && quiet && mode_q == 8'h03) |-> vc_count == 4'h8 &&
    vc_out[7].data == $past(ddc_q[3]) && vc_out[2].data == $past(ddc_i[1]))
    else $error("four ddc complex mapping wrong");
  AST_FULL_BW: assert property ($past(!rst && quiet && mode_q[3:0] == MODE_FULL_BW) |->
    vc_out[1].data == $past(adc_b) && vc_out[0].ovr == $past(adc_a_ovr && control_bits_per_sample != 2'h0))
    else $error("full bandwidth lane wrong");
  AST_STICKY: assert property (quiet && mode_q[3:0] == MODE_FULL_BW && adc_a_ovr &&
    control_bits_per_sample != 2'h0 |-> ##2 (reg_req.addr != OVR_STATUS_OFF || reg_rdata[0]))
    else $error("sticky overrange not set");
  cover property ($rose(threshold_flag_out_a));
  cover property ($fell(threshold_flag_out_a));
  cover property (vc_out[0].ctrl_k);
endmodule

bind lvdsm_top lvdsm_assertions #(.SAMPLE_W(SAMPLE_W)) u_chk (.clock(clock), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .adc_a(adc_a), .adc_b(adc_b), .adc_a_ovr(adc_a_ovr), .ddc_i(ddc_i), .ddc_q(ddc_q),
  .control_bits_per_sample(control_bits_per_sample), .powerdown_standby_pin(powerdown_standby_pin),
  .powerdown_reg(powerdown_reg), .pin_is_standby(pin_is_standby), .threshold_flag_out_a(threshold_flag_out_a),
  .threshold_flag_out_b(threshold_flag_out_b), .vc_out(vc_out), .vc_count(vc_count), .link_enable(link_enable));

// [verif/lvdsm_link_rx.sv]
// far-side link receiver model: keeps the last frame of converter samples
`timescale 1ns/100ps
module lvdsm_link_rx (
  input wire logic clock,
  input wire logic rst,
  input wire lvdsm_pkg::lvdsm_vc_s vc_out [8],
  input wire logic vc_sample_en,
  input wire logic link_enable,
  input wire logic [1:0] control_bits_per_sample,
  output lvdsm_pkg::lvdsm_vc_s rx [8],
  output int frames
);
  import lvdsm_pkg::*;
  // a halted link delivers nothing, so the old frame stays visible
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frames <= 0;
      for (int v = 0; v < NUM_VC; v++) begin
        rx[v] <= '0;
      end
    end else if (vc_sample_en && link_enable) begin
      frames <= frames + 1;
      for (int v = 0; v < NUM_VC; v++) begin
        rx[v] <= '{data: vc_out[v].data, ctrl_k: vc_out[v].ctrl_k,
          ovr: vc_out[v].ovr && control_bits_per_sample != 2'h0};
      end
    end
  end
endmodule

// [verif/lvdsm_top_test.sv]
// testbench: registers, fast detect, mapping, overrange and link state
`timescale 1ns/100ps
module lvdsm_top_test;
  import lvdsm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  lvdsm_reg_req_s reg_req = '0;
  logic [7:0] reg_rdata;
  logic [15:0] adc_a = 16'h0A0A;
  logic [15:0] adc_b = 16'h0B0B;
  logic adc_a_ovr = 1'b0;
  logic adc_b_ovr = 1'b0;
  logic [15:0] ddc_i [4];
  logic [15:0] ddc_q [4];
  logic pd_pin = 1'b0;
  logic pd_reg = 1'b0;
  logic pin_sb = 1'b0;
  logic [1:0] cbps = 2'h1;
  logic fd_a, fd_b, link_en, vc_en;
  logic [3:0] vc_count;
  lvdsm_vc_s vc_out [8];
  lvdsm_vc_s rx [8];
  int frames, f0;
  int failures = 0;
  int check_count = 0;
  logic [11:0] ca [8] = '{UPPER_LO_OFF, UPPER_HI_OFF, LOWER_LO_OFF, LOWER_HI_OFF, DWELL_LO_OFF, DWELL_HI_OFF,
    APP_MODE_OFF, DEC_RATIO_OFF};
  logic [7:0] cr [8] = '{8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
  logic [7:0] cd [8] = '{8'hFF, 8'h0F, 8'h1D, 8'h0A, 8'h04, 8'h00, 8'h00, 8'h01};
  logic [7:0] md [8] = '{8'h00, 8'h01, 8'h21, 8'h02, 8'h22, 8'h03, 8'h23, 8'h04};
  logic [3:0] nv [8] = '{4'h2, 4'h2, 4'h1, 4'h4, 4'h2, 4'h8, 4'h4, 4'h0};
  logic [15:0] lv [8] = '{16'h0B0B, 16'h2000, 16'h1000, 16'h2001, 16'h1001, 16'h2003, 16'h1003, 16'h0000};

  lvdsm_top dut (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .adc_a(adc_a), .adc_b(adc_b),
    .adc_a_ovr(adc_a_ovr), .adc_b_ovr(adc_b_ovr), .ddc_i(ddc_i), .ddc_q(ddc_q), .control_bits_per_sample(cbps),
    .powerdown_standby_pin(pd_pin), .powerdown_reg(pd_reg), .pin_is_standby(pin_sb), .threshold_flag_out_a(fd_a),
    .threshold_flag_out_b(fd_b), .vc_out(vc_out), .vc_sample_en(vc_en), .vc_count(vc_count), .link_enable(link_en));
  lvdsm_link_rx u_rx (.clock(clock), .rst(rst), .vc_out(vc_out), .vc_sample_en(vc_en), .link_enable(link_en),
    .control_bits_per_sample(cbps), .rx(rx), .frames(frames));

  initial begin
    forever #20 clock = ~clock;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_req.addr <= a;
    @(posedge clock);
    #1 chk($sformatf("reg %h", a), 16'(e), 16'(reg_rdata));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // bounded by the worst detect latency
  task automatic wait_fd(input logic ch, input logic want);
    int n;
    n = 0;
    while ((ch ? fd_b : fd_a) !== want && n < 28) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    for (int k = 0; k < 4; k++) begin
      ddc_i[k] = 16'h1000 + 16'(k);
      ddc_q[k] = 16'h2000 + 16'(k);
    end
    cyc(2);
    rst <= 1'b0;
    foreach (ca[i]) rd(ca[i], cr[i]);
    rd(12'h123, 8'h00);
    wr(OVR_STATUS_OFF, 8'hFF);
    rd(OVR_STATUS_OFF, 8'h00);
    foreach (ca[i]) wr(ca[i], cd[i]);
    foreach (ca[i]) rd(ca[i], cd[i]);
    adc_a <= 16'h4000;
    wait_fd(1'b0, 1'b1);
    chk("fd_a", 16'h1, 16'(fd_a));
    chk("fd_b", 16'h0, 16'(fd_b));
    adc_a <= 16'h0000;
    cyc(2);
    adc_a <= 16'h3000;
    cyc(1);
    adc_a <= 16'h0000;
    cyc(4);
    chk("fd_a", 16'h1, 16'(fd_a));
    wait_fd(1'b0, 1'b0);
    chk("fd_a", 16'h0, 16'(fd_a));
    adc_a <= 16'h0A0A;
    adc_b <= 16'h8000;
    wait_fd(1'b1, 1'b1);
    chk("fd_b", 16'h1, 16'(fd_b));
    adc_b <= 16'h0B0B;
    foreach (md[i]) begin
      wr(APP_MODE_OFF, md[i]);
      cyc(3);
      chk("vc_count", 16'(nv[i]), 16'(vc_count));
      if (nv[i] != 4'h0) chk("vc_last", lv[i], rx[nv[i] - 4'h1].data);
    end
    wr(DEC_RATIO_OFF, 8'h04);
    cyc(2);
    f0 = frames;
    cyc(40);
    chk("frames", 16'hA, 16'(frames - f0));
    wr(DEC_RATIO_OFF, 8'h01);
    wr(APP_MODE_OFF, 8'h00);
    adc_a_ovr <= 1'b1;
    adc_b_ovr <= 1'b1;
    cyc(1);
    adc_a_ovr <= 1'b0;
    adc_b_ovr <= 1'b0;
    cyc(1);
    chk("vc0_ovr", 16'h1, 16'(vc_out[0].ovr));
    rd(OVR_STATUS_OFF, 8'h03);
    wr(OVR_CLEAR_OFF, 8'h02);
    wr(OVR_CLEAR_OFF, 8'h00);
    rd(OVR_STATUS_OFF, 8'h01);
    cbps <= 2'h0;
    adc_a_ovr <= 1'b1;
    cyc(1);
    adc_a_ovr <= 1'b0;
    cyc(1);
    chk("vc0_ovr", 16'h0, 16'(vc_out[0].ovr));
    pin_sb <= 1'b1;
    pd_pin <= 1'b1;
    cyc(3);
    chk("link", 16'h1, 16'(link_en));
    chk("rx0", 16'h0000, rx[0].data);
    wr(STBY_PAYLOAD_OFF, 8'h80);
    cyc(3);
    chk("rx0", 16'hBCBC, rx[0].data);
    pin_sb <= 1'b0;
    cyc(2);
    chk("link", 16'h0, 16'(link_en));
    pd_pin <= 1'b0;
    pd_reg <= 1'b1;
    cyc(2);
    chk("link", 16'h0, 16'(link_en));
    end_of_test();
  end
  // the whole run is under two hundred cycles
  initial begin
    #(40 * 3000);
    failures++;
    end_of_test();
  end
endmodule
